// ---- mdu_pkg.sv ----
/*
 Constants, types and register map shared by both ends of the
 multiply/divide unit link.
 Assumes one 25 MHz clock and a synchronous active-high reset.
*/
// Summary of operation
// - Unsigned 16x16 multiply and 32/16 divide
// - Six readable writable operand bytes, no reset
// - Host writes each operand low byte first
// - Launch only on byte 5 ending valid order
// - Order counts, gaps between writes allowed
// - Order 0,1,2,3,4,5 starts 32/16 divide
// - Order 0,1,4,5 starts 16/16 divide
// - Order 0,4,1,5 starts 16x16 multiply
// - Run 17, 9 or 11 clock cycles
// - Operand access while busy sets error flag
// - Status read after completion clears error flag
// - Overflow on product above FFFF or zero divisor
// - Status low six bits zero, flags reset zero
// - Host checks status before reading results
// - Divide32 results read 0..3 then 4,5
// - Divide16 results read 0,1 then 4,5
// - Product read from bytes 0 to 3
// - Results stay intact between spaced reads
// - Host never sleeps during a calculation
// - Dividend bytes 0-3 (0-1 for 16/16), divisor bytes 4-5
// - Multiplicand 0-1, multiplier 4-5, product 0-3
package mdu_pkg;

	localparam int unsigned MDU_NUM_OPERANDS = 32'h6;
	localparam logic [2:0]  MDU_IDX_OPERAND0 = 3'h0;
	localparam logic [2:0]  MDU_IDX_OPERAND1 = 3'h1;
	localparam logic [2:0]  MDU_IDX_OPERAND2 = 3'h2;
	localparam logic [2:0]  MDU_IDX_OPERAND3 = 3'h3;
	localparam logic [2:0]  MDU_IDX_OPERAND4 = 3'h4;
	localparam logic [2:0]  MDU_IDX_OPERAND5 = 3'h5;
	localparam logic [2:0]  MDU_IDX_STATUS   = 3'h6;
	localparam int unsigned MDU_ERR_BIT      = 32'h7;
	localparam int unsigned MDU_OV_BIT       = 32'h6;
	localparam logic [7:0]  MDU_STATUS_RESET = 8'h00;
	localparam logic [4:0]  MDU_CYC_DIV32    = 5'h11;
	localparam logic [4:0]  MDU_CYC_DIV16    = 5'h09;
	localparam logic [4:0]  MDU_CYC_MUL      = 5'h0B;
	localparam logic [31:0] MDU_MUL_LIMIT    = 32'h0000FFFF;

	// Host command port map
	localparam logic [2:0]  MDU_H_CTRL   = 3'h0;
	localparam logic [2:0]  MDU_H_OPA    = 3'h1;
	localparam logic [2:0]  MDU_H_OPB    = 3'h2;
	localparam logic [2:0]  MDU_H_STATUS = 3'h3;
	localparam logic [2:0]  MDU_H_RESULT = 3'h4;
	localparam logic [2:0]  MDU_H_REM    = 3'h5;
	localparam int unsigned MDU_H_START_BIT = 32'h2;

	typedef enum logic [1:0] {
		MDU_OP_DIV32 = 2'h0,
		MDU_OP_DIV16 = 2'h1,
		MDU_OP_MUL   = 2'h2
	} mdu_op_type;

	typedef enum logic [8:0] {
		MDU_T_IDLE  = 9'h001,
		MDU_T_0     = 9'h002,
		MDU_T_01    = 9'h004,
		MDU_T_012   = 9'h008,
		MDU_T_0123  = 9'h010,
		MDU_T_01234 = 9'h020,
		MDU_T_014   = 9'h040,
		MDU_T_04    = 9'h080,
		MDU_T_041   = 9'h100
	} mdu_track_type;

	typedef enum logic [6:0] {
		MDU_H_IDLE  = 7'h01,
		MDU_H_WRITE = 7'h02,
		MDU_H_WAIT  = 7'h04,
		MDU_H_RISS  = 7'h08,
		MDU_H_RGAP  = 7'h10,
		MDU_H_RCAP  = 7'h20,
		MDU_H_DONE  = 7'h40
	} mdu_hstate_type;

endpackage

// ---- mdu_if.sv ----
/*
 Byte register link between the host end and the multiply/divide
 unit. Assumes both ends share one clock; read data follow one cycle
 after the read strobe.
*/
`timescale 1ns/1ps
interface mdu_if;
	logic [2:0] addr;
	logic [7:0] wdata;
	logic       wr;
	logic       rd;
	logic [7:0] rdata;

	modport dev (
		input  addr,
		input  wdata,
		input  wr,
		input  rd,
		output rdata
	);

	modport host (
		output addr,
		output wdata,
		output wr,
		output rd,
		input  rdata
	);
endinterface

// ---- mdu_device.sv ----
/*
 Multiply/divide unit: six operand bytes, order tracker, timed
 calculation, status with error and overflow flags.
 Assumes a host on mdu_if with one-cycle strobes and one clock.
*/
// Added by the designer: the strobed register port and the register addresses.
`timescale 1ns/1ps
module mdu_device (
	input  wire logic clk,
	input  wire logic rst,
	mdu_if.dev        bus,
	output      logic calc_busy
);
	import mdu_pkg::*;

	////////////////////////////////////////////////////////////////
	// Order tracking

	function automatic mdu_track_type track_next(
		input mdu_track_type s,
		input logic [2:0]    a
	);
		mdu_track_type n;
		n = MDU_T_IDLE;
		case (a)
			MDU_IDX_OPERAND0: n = MDU_T_0;
			MDU_IDX_OPERAND1: begin
				if (s == MDU_T_0)
					n = MDU_T_01;
				else if (s == MDU_T_04)
					n = MDU_T_041;
			end
			MDU_IDX_OPERAND2: begin
				if (s == MDU_T_01)
					n = MDU_T_012;
			end
			MDU_IDX_OPERAND3: begin
				if (s == MDU_T_012)
					n = MDU_T_0123;
			end
			MDU_IDX_OPERAND4: begin
				if (s == MDU_T_0)
					n = MDU_T_04;
				else if (s == MDU_T_01)
					n = MDU_T_014;
				else if (s == MDU_T_0123)
					n = MDU_T_01234;
			end
			default: n = MDU_T_IDLE;
		endcase
		return n;
	endfunction

	mdu_track_type track_q;
	mdu_track_type track_d;
	mdu_op_type    op_q;
	logic          busy_q;
	logic [4:0]    cnt_q;
	logic          err_q;
	logic          ov_q;
	logic [7:0]    rdata_q;
	wire  [47:0]   regs_w;

	wire opnd_hit  = (bus.addr <= MDU_IDX_OPERAND5);
	wire stat_hit  = (bus.addr == MDU_IDX_STATUS);
	wire violation = busy_q && opnd_hit && (bus.wr || bus.rd);
	wire wr_ok     = bus.wr && !busy_q && opnd_hit;
	wire wr_last   = wr_ok && (bus.addr == MDU_IDX_OPERAND5);

	wire go_div32  = wr_last && (track_q == MDU_T_01234);
	wire go_div16  = wr_last && (track_q == MDU_T_014);
	wire go_mul    = wr_last && (track_q == MDU_T_041);
	wire launch    = go_div32 || go_div16 || go_mul;
	wire finish    = busy_q && (cnt_q == 5'h01);

	// Only writes move the tracker; reads and idle cycles do not
	always_comb begin
		track_d = track_q;
		if (wr_ok)
			track_d = track_next(track_q, bus.addr);
	end

	always_ff @(posedge clk) begin
		if (rst)
			track_q <= MDU_T_IDLE;
		else
			track_q <= track_d;
	end

	////////////////////////////////////////////////////////////////
	// Calculation

	wire [15:0] divisor  = regs_w[47:32];
	wire        div_zero = (divisor == 16'h0000);
	wire [31:0] dividend = (op_q == MDU_OP_DIV32) ? regs_w[31:0]
	                       : {16'h0000, regs_w[15:0]};
	wire [31:0] div_safe = div_zero ? 32'h00000001
	                       : {16'h0000, divisor};
	wire [31:0] quot     = dividend / div_safe;
	wire [31:0] rem_full = dividend % div_safe;
	wire [15:0] remain   = rem_full[15:0];
	wire [31:0] product  = regs_w[15:0] * regs_w[47:32];
	wire        ov_new   = (op_q == MDU_OP_MUL) ? (product > MDU_MUL_LIMIT)
	                       : div_zero;

	logic [47:0] res_w;
	logic [5:0]  res_we;

	always_comb begin
		case (op_q)
			MDU_OP_DIV32: begin
				res_w  = {remain, quot};
				res_we = 6'h3F;
			end
			MDU_OP_DIV16: begin
				res_w  = {remain, 16'h0000, quot[15:0]};
				res_we = 6'h33;
			end
			MDU_OP_MUL: begin
				res_w  = {16'h0000, product};
				res_we = 6'h0F;
			end
			default: begin
				res_w  = 48'h000000000000;
				res_we = 6'h00;
			end
		endcase
	end

	always_ff @(posedge clk) begin
		if (rst) begin
			busy_q <= 1'b0;
			cnt_q  <= 5'h00;
			op_q   <= MDU_OP_DIV32;
		end else if (launch) begin
			busy_q <= 1'b1;
			if (go_div32) begin
				op_q  <= MDU_OP_DIV32;
				cnt_q <= MDU_CYC_DIV32;
			end else if (go_div16) begin
				op_q  <= MDU_OP_DIV16;
				cnt_q <= MDU_CYC_DIV16;
			end else begin
				op_q  <= MDU_OP_MUL;
				cnt_q <= MDU_CYC_MUL;
			end
		end else if (busy_q) begin
			cnt_q <= cnt_q - 5'h01;
			if (finish)
				busy_q <= 1'b0;
		end
	end

	////////////////////////////////////////////////////////////////
	// Operand bytes: no reset, contents unknown at power-on

	genvar gi;
	generate
		for (gi = 0; gi < MDU_NUM_OPERANDS; gi = gi + 1) begin : g_opnd
			logic [7:0] byte_q;
			wire        hit = (bus.addr == 3'(gi));
			always_ff @(posedge clk) begin
				if (wr_ok && hit)
					byte_q <= bus.wdata;
				else if (finish && res_we[gi])
					byte_q <= res_w[8*gi +: 8];
			end
			assign regs_w[8*gi +: 8] = byte_q;
		end
	endgenerate

	////////////////////////////////////////////////////////////////
	// Status flags and read port

	wire stat_rd   = bus.rd && stat_hit;
	wire err_clear = stat_rd && err_q && !busy_q;

	always_ff @(posedge clk) begin
		if (rst) begin
			err_q <= MDU_STATUS_RESET[MDU_ERR_BIT];
			ov_q  <= MDU_STATUS_RESET[MDU_OV_BIT];
		end else begin
			if (violation)
				err_q <= 1'b1;
			else if (err_clear)
				err_q <= 1'b0;
			if (finish)
				ov_q <= ov_new;
		end
	end

	// Reads never disturb stored results
	wire [7:0] status_w = {err_q, ov_q, 6'h00};
	wire [7:0] opnd_w   = regs_w[{bus.addr, 3'h0} +: 8];
	wire [7:0] rd_sel   = opnd_hit ? opnd_w
	                      : (stat_hit ? status_w : 8'h00);

	always_ff @(posedge clk) begin
		if (rst)
			rdata_q <= 8'h00;
		else if (bus.rd)
			rdata_q <= rd_sel;
		else
			rdata_q <= 8'h00;
	end

	assign bus.rdata = rdata_q;
	assign calc_busy = busy_q;

endmodule

// ---- mdu_host.sv ----
/*
 Host end: takes a command from software, writes operands in the
 order that selects the operation, waits out the calculation, checks
 status, then collects results. Assumes the unit on mdu_if.
*/
`timescale 1ns/1ps
module mdu_host (
	input  wire logic        clk,
	input  wire logic        rst,
	mdu_if.host              bus,
	input  wire logic [2:0]  sw_addr,
	input  wire logic [31:0] sw_wdata,
	input  wire logic        sw_wr,
	input  wire logic        sw_rd,
	output      logic [31:0] sw_rdata
);
	import mdu_pkg::*;

	// Byte index for a step of the write or read order
	function automatic logic [2:0] seq_idx(
		input mdu_op_type op,
		input logic       rd,
		input logic [2:0] st
	);
		logic [2:0] r;
		r = st;
		if (op == MDU_OP_DIV16 && st[1])
			r = {1'b1, 1'b0, st[0]};
		else if (op == MDU_OP_MUL && !rd)
			r = {st[0], 1'b0, st[1]};
		return r;
	endfunction

	function automatic logic [2:0] seq_last(input mdu_op_type op);
		return (op == MDU_OP_DIV32) ? 3'h5 : 3'h3;
	endfunction

	mdu_hstate_type st_q;
	mdu_op_type     op_q;
	logic [31:0]    opa_q;
	logic [15:0]    opb_q;
	logic [31:0]    res_q;
	logic [15:0]    rem_q;
	logic           done_q;
	logic           err_q;
	logic           ov_q;
	logic           stat_ph_q;
	logic [2:0]     step_q;
	logic [4:0]     wait_q;
	logic [2:0]     addr_q;
	logic [7:0]     wdata_q;
	logic           wr_q;
	logic           rd_q;
	logic [31:0]    sw_rdata_q;

	wire        idle   = (st_q == MDU_H_IDLE);
	wire        start  = sw_wr && idle && (sw_addr == MDU_H_CTRL)
	                     && sw_wdata[MDU_H_START_BIT]
	                     && (sw_wdata[1:0] != 2'h3);
	// Write order only while writing; reads follow the plain result order
	wire [2:0]  cur    = seq_idx(op_q, st_q != MDU_H_WRITE, step_q);
	wire [47:0] opnd   = {opb_q, opa_q};
	wire        last   = (step_q == seq_last(op_q));
	wire [4:0]  cyc    = (op_q == MDU_OP_DIV32) ? MDU_CYC_DIV32
	                     : ((op_q == MDU_OP_DIV16) ? MDU_CYC_DIV16 : MDU_CYC_MUL);

	////////////////////////////////////////////////////////////////
	// Sequencer

	always_ff @(posedge clk) begin
		if (rst) begin
			st_q      <= MDU_H_IDLE;
			op_q      <= MDU_OP_DIV32;
			step_q    <= 3'h0;
			wait_q    <= 5'h00;
			stat_ph_q <= 1'b0;
			addr_q    <= 3'h0;
			wdata_q   <= 8'h00;
			wr_q      <= 1'b0;
			rd_q      <= 1'b0;
			done_q    <= 1'b0;
			err_q     <= 1'b0;
			ov_q      <= 1'b0;
			res_q     <= 32'h00000000;
			rem_q     <= 16'h0000;
		end else begin
			wr_q <= 1'b0;
			rd_q <= 1'b0;
			case (st_q)
				MDU_H_IDLE: begin
					if (start) begin
						op_q   <= mdu_op_type'(sw_wdata[1:0]);
						step_q <= 3'h0;
						done_q <= 1'b0;
						st_q   <= MDU_H_WRITE;
					end
				end
				MDU_H_WRITE: begin
					wr_q    <= 1'b1;
					addr_q  <= cur;
					wdata_q <= opnd[{cur, 3'h0} +: 8];
					step_q  <= step_q + 3'h1;
					if (last) begin
						wait_q <= cyc;
						st_q   <= MDU_H_WAIT;
					end
				end
				MDU_H_WAIT: begin
					// No access until the unit is done; never sleep here
					if (wait_q == 5'h00) begin
						stat_ph_q <= 1'b1;
						st_q      <= MDU_H_RISS;
					end else
						wait_q <= wait_q - 5'h01;
				end
				MDU_H_RISS: begin
					rd_q   <= 1'b1;
					addr_q <= stat_ph_q ? MDU_IDX_STATUS : cur;
					st_q   <= MDU_H_RGAP;
				end
				MDU_H_RGAP: st_q <= MDU_H_RCAP;
				MDU_H_RCAP: begin
					if (stat_ph_q) begin
						err_q     <= bus.rdata[MDU_ERR_BIT];
						ov_q      <= bus.rdata[MDU_OV_BIT];
						stat_ph_q <= 1'b0;
						step_q    <= 3'h0;
						st_q      <= bus.rdata[MDU_ERR_BIT] ? MDU_H_DONE : MDU_H_RISS;
					end else begin
						if (cur[2])
							rem_q[{cur[0], 3'h0} +: 8] <= bus.rdata;
						else
							res_q[{cur[1:0], 3'h0} +: 8] <= bus.rdata;
						step_q <= step_q + 3'h1;
						st_q   <= (step_q == 3'h3 && op_q != MDU_OP_DIV32)
						          || step_q == 3'h5 ? MDU_H_DONE : MDU_H_RISS;
					end
				end
				MDU_H_DONE: begin
					done_q <= 1'b1;
					st_q   <= MDU_H_IDLE;
				end
				default: st_q <= MDU_H_IDLE;
			endcase
		end
	end

	////////////////////////////////////////////////////////////////
	// Software port

	always_ff @(posedge clk) begin
		if (rst) begin
			opa_q <= 32'h00000000;
			opb_q <= 16'h0000;
		end else if (sw_wr && idle) begin
			if (sw_addr == MDU_H_OPA)
				opa_q <= sw_wdata;
			if (sw_addr == MDU_H_OPB)
				opb_q <= sw_wdata[15:0];
		end
	end

	wire [31:0] stat_w = {28'h0000000, !idle, done_q, err_q, ov_q};
	wire [31:0] sw_sel = (sw_addr == MDU_H_OPA)    ? opa_q
	                   : (sw_addr == MDU_H_OPB)    ? {16'h0000, opb_q}
	                   : (sw_addr == MDU_H_STATUS) ? stat_w
	                   : (sw_addr == MDU_H_RESULT) ? res_q
	                   : (sw_addr == MDU_H_REM)    ? {16'h0000, rem_q}
	                   : 32'h00000000;

	always_ff @(posedge clk) begin
		if (rst)
			sw_rdata_q <= 32'h00000000;
		else
			sw_rdata_q <= sw_rd ? sw_sel : 32'h00000000;
	end

	assign bus.addr  = addr_q;
	assign bus.wdata = wdata_q;
	assign bus.wr    = wr_q;
	assign bus.rd    = rd_q;
	assign sw_rdata  = sw_rdata_q;

endmodule

// ---- mdu_properties.sv ----
/*
 Checker for the link joining host end and unit.
 Assumes plain inputs wired to that link and to the unit's busy.
*/
`timescale 1ns/1ps
module mdu_properties (
	input wire logic       clk,
	input wire logic       rst,
	input wire logic [2:0] addr,
	input wire logic       wr,
	input wire logic       rd,
	input wire logic [7:0] rdata,
	input wire logic       calc_busy
);
	logic [4:0] run_q;
	logic [2:0] lwr_q;
	logic [2:0] lrd_q;
	logic       seen_q;

	default clocking cb @(posedge clk);
	endclocking
	default disable iff (rst);

	// Busy length, last operand written and read, status read since last write
	always_ff @(posedge clk) begin
		run_q  <= (rst || !calc_busy) ? 5'h00 : run_q + 5'h01;
		lwr_q  <= wr ? addr : lwr_q;
		lrd_q  <= (rd && addr < 3'h6) ? addr : lrd_q;
		seen_q <= (rst || wr) ? 1'b0 : (seen_q || (rd && addr == 3'h6));
	end

	////////////////////////////////////////////////////////////////////////
	sequence s_last_write;
		wr && addr == 3'h5;
	endsequence
	sequence s_run;
		calc_busy [*8];
	endsequence
	property p_launch;
		s_last_write |=> s_run;
	endproperty
	property p_cause;
		$rose(calc_busy) |-> $past(wr) && $past(addr) == 3'h5;
	endproperty
	property p_len;
		$fell(calc_busy) |-> run_q == 5'h11 || run_q == 5'h09 || run_q == 5'h0B;
	endproperty
	property p_quiet;
		(wr || rd) && addr < 3'h6 |-> !calc_busy;
	endproperty
	property p_status;
		$past(rd) && $past(addr) == 3'h6 |-> rdata[7] == 1'b0 && rdata[5:0] == 6'h00;
	endproperty
	property p_check_first;
		rd && addr < 3'h6 |-> seen_q;
	endproperty
	property p_wr_order;
		wr && addr == 3'h5 |-> lwr_q == 3'h4 || lwr_q == 3'h1;
	endproperty
	property p_rd_order;
		rd && addr != 3'h0 && addr < 3'h6 |-> lrd_q == addr - 3'h1 || (addr == 3'h4 && lrd_q == 3'h1);
	endproperty

	a_launch: assert property (p_launch)
		else $error("no run after last operand write");
	a_cause: assert property (p_cause)
		else $error("run started without last operand write");
	a_len: assert property (p_len)
		else $error("run length wrong");
	a_quiet: assert property (p_quiet)
		else $error("operand access while running");
	a_status: assert property (p_status)
		else $error("status byte wrong");
	a_check_first: assert property (p_check_first)
		else $error("result read before status read");
	a_wr_order: assert property (p_wr_order)
		else $error("last operand byte out of order");
	a_rd_order: assert property (p_rd_order)
		else $error("result bytes read out of order");
endmodule

// ---- test_byte_port_multiply_divide_unit.sv ----
/*
 Testbench: host end and unit joined on one link, plus a second unit
 driven directly for orders, timing and access faults.
 Assumes one 25 MHz clock and synchronous active-high reset.
*/
`timescale 1ns/1ps
module test_byte_port_multiply_divide_unit;
	import mdu_pkg::*;
	logic        clk = 1'b0;
	logic        rst = 1'b1;
	logic [2:0]  sw_addr = 3'h0;
	logic [31:0] sw_wdata = 32'h0;
	logic        sw_wr = 1'b0;
	logic        sw_rd = 1'b0;
	logic [31:0] sw_rdata;
	logic        busy_a;
	logic        busy_b;
	int          mismatches = 0;
	int          n_compared = 0;

	mdu_if link_a ();
	mdu_if link_b ();

	always #20 clk = ~clk;

	mdu_host mdu_host_inst (.clk(clk), .rst(rst), .bus(link_a), .sw_addr(sw_addr),
		.sw_wdata(sw_wdata), .sw_wr(sw_wr), .sw_rd(sw_rd), .sw_rdata(sw_rdata));
	mdu_device mdu_device_inst (.clk(clk), .rst(rst), .bus(link_a), .calc_busy(busy_a));
	mdu_device mdu_device_inst_b (.clk(clk), .rst(rst), .bus(link_b), .calc_busy(busy_b));
	mdu_properties mdu_properties_inst (.clk(clk), .rst(rst), .addr(link_a.addr),
		.wr(link_a.wr), .rd(link_a.rd), .rdata(link_a.rdata), .calc_busy(busy_a));

	////////////////////////////////////////////////////////////////////////
	task automatic check(input logic [31:0] seen, input logic [31:0] exp);
		n_compared++;
		if (seen !== exp) begin
			mismatches++;
			$display("[FAIL] %0t seen %h expected %h", $time, seen, exp);
		end
	endtask

	task automatic give_verdict;
		if (mismatches == 0 && n_compared > 0)
			$display("bench passed");
		else
			$display("bench failed");
		$finish;
	endtask

	task automatic bw(input logic [2:0] a, input logic [7:0] d);
		link_b.addr <= a;
		link_b.wdata <= d;
		link_b.wr <= 1'b1;
		@(posedge clk);
		link_b.wr <= 1'b0;
		link_b.wdata <= ~d;
		@(posedge clk);
	endtask

	task automatic br(input logic [2:0] a, output logic [7:0] d);
		link_b.addr <= a;
		link_b.rd <= 1'b1;
		@(posedge clk);
		link_b.rd <= 1'b0;
		#1 d = link_b.rdata;
		@(posedge clk);
	endtask

	task automatic sw_write(input logic [2:0] a, input logic [31:0] d);
		sw_addr <= a;
		sw_wdata <= d;
		sw_wr <= 1'b1;
		@(posedge clk);
		sw_wr <= 1'b0;
		@(posedge clk);
	endtask

	task automatic sw_read(input logic [2:0] a, output logic [31:0] d);
		sw_addr <= a;
		sw_rd <= 1'b1;
		@(posedge clk);
		sw_rd <= 1'b0;
		#1 d = sw_rdata;
		@(posedge clk);
	endtask

	// Expected {overflow, remainder, quotient or product}
	function automatic logic [48:0] calc(input mdu_op_type op, input logic [31:0] a,
		input logic [15:0] b);
		logic [31:0] q;
		if (op == MDU_OP_MUL)
			q = a[15:0] * b;
		else if (b == 16'h0)
			q = a;
		else
			q = a / b;
		return {op == MDU_OP_MUL ? q > MDU_MUL_LIMIT : b == 16'h0,
			b == 16'h0 ? 16'h0 : 16'(a % b), q};
	endfunction

	////////////////////////////////////////////////////////////////////////
	task automatic host_op(input mdu_op_type op, input logic [31:0] a, input logic [15:0] b);
		logic [48:0] e;
		logic [31:0] d;
		logic [31:0] m;
		int          n;
		e = calc(op, a, b);
		m = (op == MDU_OP_DIV16) ? 32'h0000FFFF : 32'hFFFFFFFF;
		d = 32'h0;
		n = 0;
		sw_write(MDU_H_OPA, a);
		sw_write(MDU_H_OPB, {16'h0000, b});
		sw_write(MDU_H_CTRL, {29'h0, 1'b1, op});
		while (d[2] !== 1'b1 && n < 100) begin
			sw_read(MDU_H_STATUS, d);
			n++;
		end
		check({28'h0, d[3:0]}, {28'h0, 3'b010, e[48]});
		sw_read(MDU_H_RESULT, d);
		check(d & m, e[31:0] & m);
		sw_read(MDU_H_REM, d);
		if (op != MDU_OP_MUL)
			check({16'h0, d[15:0]}, {16'h0, e[47:32]});
	endtask

	// Op code 3 is refused: the host stays idle and keeps its last status
	task automatic host_bad_op;
		logic [31:0] d;
		sw_write(MDU_H_CTRL, 32'h00000007);
		sw_read(MDU_H_STATUS, d);
		check({28'h0, d[3:0]}, 32'h00000005);
		check({31'h0, busy_a}, 32'h0);
	endtask

	task automatic b_basic;
		logic [7:0] d;
		br(MDU_IDX_STATUS, d);
		check({24'h0, d}, {24'h0, MDU_STATUS_RESET});
		br(3'h7, d);
		check({24'h0, d}, 32'h0);
		bw(MDU_IDX_OPERAND2, 8'hA5);
		br(MDU_IDX_OPERAND2, d);
		check({24'h0, d}, 32'hA5);
		bw(MDU_IDX_OPERAND0, 8'h01);
		bw(MDU_IDX_OPERAND1, 8'h02);
		bw(MDU_IDX_OPERAND2, 8'h03);
		bw(MDU_IDX_OPERAND5, 8'h04);
		check({31'h0, busy_b}, 32'h0);
	endtask

	// Ordered writes with status reads between, timed run, then spaced result reads
	task automatic b_op(input mdu_op_type op, input logic [31:0] a, input logic [15:0] b,
		input logic viol);
		logic [48:0] e;
		logic [47:0] v;
		logic [7:0]  d;
		int          ord [6];
		int          n;
		e = calc(op, a, b);
		v = {b, a};
		case (op)
			MDU_OP_DIV32: ord = '{0, 1, 2, 3, 4, 5};
			MDU_OP_DIV16: ord = '{0, 1, 4, 5, 6, 6};
			default: ord = '{0, 4, 1, 5, 6, 6};
		endcase
		foreach (ord[k]) begin
			if (ord[k] < 6) begin
				br(MDU_IDX_STATUS, d);
				bw(3'(ord[k]), v[8 * ord[k] +: 8]);
			end
		end
		n = viol ? 3 : 1;
		if (viol)
			bw(MDU_IDX_OPERAND0, 8'h5A);
		#1;
		while (busy_b === 1'b1 && n < 40) begin
			@(posedge clk);
			#1;
			n++;
		end
		@(posedge clk);
		check(n, op == MDU_OP_DIV32 ? MDU_CYC_DIV32 :
			op == MDU_OP_DIV16 ? MDU_CYC_DIV16 : MDU_CYC_MUL);
		br(MDU_IDX_STATUS, d);
		check({24'h0, d}, {24'h0, viol, e[48], 6'h00});
		br(MDU_IDX_STATUS, d);
		check({24'h0, d}, {24'h0, 1'b0, e[48], 6'h00});
		if (op == MDU_OP_MUL)
			ord = '{0, 1, 2, 3, 6, 6};
		foreach (ord[k]) begin
			if (ord[k] < 6) begin
				br(3'(ord[k]), d);
				check({24'h0, d}, {24'h0, e[8 * ord[k] +: 8]});
				br(MDU_IDX_STATUS, d);
			end
		end
	endtask

	////////////////////////////////////////////////////////////////////////
	initial begin
		#400000;
		mismatches++;
		give_verdict();
	end

	initial begin
		link_b.addr = 3'h0;
		link_b.wdata = 8'h00;
		link_b.wr = 1'b0;
		link_b.rd = 1'b0;
		repeat (4) @(posedge clk);
		rst <= 1'b0;
		b_basic();
		b_op(MDU_OP_DIV32, 32'h12345678, 16'h0123, 1'b0);
		b_op(MDU_OP_DIV16, 32'h0000BEEF, 16'h0007, 1'b0);
		b_op(MDU_OP_MUL, 32'h0000ABCD, 16'h1234, 1'b0);
		b_op(MDU_OP_MUL, 32'h000000FF, 16'h0101, 1'b1);
		host_op(MDU_OP_DIV32, 32'hFEDCBA98, 16'hF00D);
		host_op(MDU_OP_DIV16, 32'h0000FFFF, 16'h0100);
		host_op(MDU_OP_MUL, 32'h000000FF, 16'h0101);
		host_op(MDU_OP_MUL, 32'h00000100, 16'h0100);
		host_op(MDU_OP_DIV32, 32'h00C0FFEE, 16'h0000);
		host_bad_op();
		give_verdict();
	end
endmodule
